// ===== rtl/chs_top.sv
// Purpose: Channel select register with channel write steering and serial mode control
// Assumes: Framing logic presents each completed register write as a one-cycle pulse
// Notes: Mode and bit order reach the serial port only between transfers
//
// What this block does
// - Channel select is one byte at zero.
// - Reset selects all four channels.
// - Enables act at once, no update strobe.
// - Shared writes reach only enabled channel copies.
// - Enable bit n selects channel n.
// - Mode codes 00, 01 give two/three-wire.
// - Mode codes 10, 11 give two/four-bit.
// - Bit order clear means MSB first, reset.
// - Bit order set means LSB first.
`timescale 1ns/100ps
module chs_top
  import chs_pkg::*;
#(
  parameter int NUM_CHAN = 4,
  parameter int DATA_W = 32
)
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic reg_wr_i,
  input wire logic [4:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic xfer_active_i,
  output logic [7:0] channel_select_o,
  output logic [NUM_CHAN-1:0] chan_en_o,
  output logic [NUM_CHAN-1:0] chan_wr_o,
  output logic [4:0] chan_addr_o,
  output logic [DATA_W-1:0] chan_wdata_o,
  output logic [1:0] serial_mode_o,
  output logic mode_two_wire_o,
  output logic mode_three_wire_o,
  output logic mode_dual_o,
  output logic mode_quad_o,
  output logic lsb_first_o
);

  // ==========================================================================
  // Register state
  logic [7:0] sel_d;
  logic [7:0] sel_q;
  logic sel_wr;

  // Applied serial settings
  logic [1:0] mode_d;
  logic [1:0] mode_q;
  logic [3:0] mode_oh_d;
  logic [3:0] mode_oh_q;
  logic lsb_d;
  logic lsb_q;

  // ==========================================================================
  // Channel select register
  assign sel_wr = reg_wr_i && (reg_addr_i == CHS_SEL_ADDR);

  always_comb
  begin
    sel_d = sel_q;
    if (sel_wr)
    begin
      // Bit three stored as written; host keeps it zero
      sel_d = reg_wdata_i[CHS_SEL_W-1:0];
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sel_q <= CHS_SEL_RESET;
    end
    else
    begin
      sel_q <= sel_d;
    end
  end

  // ==========================================================================
  // Serial settings, taken over only while no transfer runs
  always_comb
  begin
    mode_d = mode_q;
    lsb_d = lsb_q;
    mode_oh_d = mode_oh_q;
    if (!xfer_active_i)
    begin
      mode_d = sel_q[CHS_MODE_MSB:CHS_MODE_LSB];
      lsb_d = sel_q[CHS_ORDER_BIT];
      mode_oh_d = chs_mode_onehot(sel_q[CHS_MODE_MSB:CHS_MODE_LSB]);
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      mode_q <= CHS_SEL_RESET[CHS_MODE_MSB:CHS_MODE_LSB];
      lsb_q <= CHS_SEL_RESET[CHS_ORDER_BIT];
      mode_oh_q <= CHS_MODE_OH_RESET;
    end
    else
    begin
      mode_q <= mode_d;
      lsb_q <= lsb_d;
      mode_oh_q <= mode_oh_d;
    end
  end

  // ==========================================================================
  // Write steering
  chs_steer_if #(.NUM_CHAN(NUM_CHAN), .DATA_W(DATA_W)) sif ();

  assign sif.wr = reg_wr_i;
  assign sif.addr = reg_addr_i;
  assign sif.data = reg_wdata_i;
  assign sif.en = sel_q[CHS_EN_LSB +: NUM_CHAN];

  chs_steer #(.NUM_CHAN(NUM_CHAN), .DATA_W(DATA_W)) u_steer
  (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .sif(sif)
  );

  // ==========================================================================
  // Outputs
  assign channel_select_o = sel_q;
  assign chan_en_o = sel_q[CHS_EN_LSB +: NUM_CHAN];
  assign chan_wr_o = sif.chan_wr;
  assign chan_addr_o = sif.chan_addr;
  assign chan_wdata_o = sif.chan_data;
  assign serial_mode_o = mode_q;
  assign mode_two_wire_o = mode_oh_q[0];
  assign mode_three_wire_o = mode_oh_q[1];
  assign mode_dual_o = mode_oh_q[2];
  assign mode_quad_o = mode_oh_q[3];
  assign lsb_first_o = lsb_q;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);

  a_sel_write_store: assert property (
    (reg_wr_i && (reg_addr_i == CHS_SEL_ADDR))
    |=> (channel_select_o == $past(reg_wdata_i[7:0])))
  else $error("Channel select did not store the written byte");

  a_sel_other_hold: assert property (
    (!reg_wr_i || (reg_addr_i != CHS_SEL_ADDR)) |=> $stable(channel_select_o))
  else $error("Channel select changed without a write to it");

  a_sel_no_steer: assert property (
    (reg_wr_i && (reg_addr_i == CHS_SEL_ADDR)) |=> (chan_wr_o == '0))
  else $error("Channel strobe on a channel select write");

  a_reset_value: assert property (
    @(posedge clock_i) disable iff (1'b0)
    $rose(rst_n_i) |-> ((channel_select_o == 8'hf0) && !lsb_first_o))
  else $error("Reset value wrong");

  a_enable_at_once: assert property (
    (reg_wr_i && (reg_addr_i == CHS_SEL_ADDR))
    ##1 (reg_wr_i && chs_is_chan_addr(reg_addr_i))
    |=> (chan_wr_o == $past(reg_wdata_i[7:4], 2)))
  else $error("Channel write used stale enables");

  a_enable_bit_map: assert property (
    (reg_wr_i && chs_is_chan_addr(reg_addr_i) && (chan_en_o == 4'h9))
    |=> (chan_wr_o == 4'h9))
  else $error("Pattern 1001 did not select channels 3 and 0");

  a_enable_bit_one: assert property (
    (reg_wr_i && chs_is_chan_addr(reg_addr_i) && (chan_en_o == 4'h2))
    |=> (chan_wr_o == 4'h2))
  else $error("Pattern 0010 did not select channel 1");

  a_mode_hold_xfer: assert property (
    xfer_active_i |=> ($stable(serial_mode_o) && $stable(lsb_first_o)))
  else $error("Serial settings changed inside a transfer");

  a_mode_two_wire: assert property (
    (!xfer_active_i && (sel_q[2:1] == 2'h0))
    |=> (mode_two_wire_o && !mode_three_wire_o && !mode_dual_o && !mode_quad_o))
  else $error("Code 00 did not give two-wire mode");

  a_mode_wire: assert property (
    (!xfer_active_i && (sel_q[2:1] == 2'h1))
    |=> (mode_three_wire_o && !mode_two_wire_o && !mode_dual_o && !mode_quad_o))
  else $error("Code 01 did not give three-wire mode");

  a_mode_dual: assert property (
    (!xfer_active_i && (sel_q[2:1] == 2'h2))
    |=> (mode_dual_o && !mode_quad_o && !mode_two_wire_o && (serial_mode_o == 2'h2)))
  else $error("Code 10 did not give two-bit mode");

  a_mode_quad: assert property (
    (!xfer_active_i && (sel_q[2:1] == 2'h3))
    |=> (mode_quad_o && !mode_dual_o && (serial_mode_o == 2'h3)))
  else $error("Code 11 did not give four-bit mode");

  a_order_msb: assert property (
    (!xfer_active_i && !sel_q[0]) |=> !lsb_first_o)
  else $error("Clear order bit did not give MSB first");

  a_order_lsb: assert property (
    (!xfer_active_i && sel_q[0]) |=> lsb_first_o)
  else $error("Set order bit did not give LSB first");

  a_apply_after_xfer: assert property (
    (xfer_active_i && sel_wr) ##1 xfer_active_i ##1 !xfer_active_i
    |=> ((serial_mode_o == $past(sel_q[2:1])) && (lsb_first_o == $past(sel_q[0]))))
  else $error("New mode not applied after the transfer");

endmodule

// ===== include/chs_pkg.sv
// Purpose: Shared constants and types for the channel select register block
// Assumes: Register addresses are five bits wide, as carried by the serial framing logic
// Notes: Channel and profile copies live in the channel slices outside this block
package chs_pkg;

  // ==========================================================================
  // Register space
  localparam int CHS_ADDR_W = 5;
  localparam int CHS_DATA_W = 32;
  localparam int CHS_SEL_W = 8;
  localparam logic [4:0] CHS_SEL_ADDR = 5'h00;
  localparam logic [4:0] CHS_CHAN_ADDR_LO = 5'h03;
  localparam logic [4:0] CHS_PROF_ADDR_HI = 5'h18;

  // ==========================================================================
  // Field layout and reset value
  localparam int CHS_EN_MSB = 7;
  localparam int CHS_EN_LSB = 4;
  localparam int CHS_ZERO_BIT = 3;
  localparam int CHS_MODE_MSB = 2;
  localparam int CHS_MODE_LSB = 1;
  localparam int CHS_ORDER_BIT = 0;
  localparam logic [7:0] CHS_SEL_RESET = 8'hf0;
  // Two-wire mode flag set, matching mode code 00 at reset
  localparam logic [3:0] CHS_MODE_OH_RESET = 4'h1;

  // ==========================================================================
  // Serial modes
  typedef enum logic [1:0]
  {
    CHS_MODE_2W = 2'h0,
    CHS_MODE_3W = 2'h1,
    CHS_MODE_DUAL = 2'h2,
    CHS_MODE_QUAD = 2'h3
  } chs_mode_t;

  // One-hot view: bit 0 two-wire, 1 three-wire, 2 two-bit, 3 four-bit
  function automatic logic [3:0] chs_mode_onehot(input logic [1:0] mode);
    logic [3:0] oh;
    oh = 4'h0;
    case (mode)
      CHS_MODE_2W: oh = 4'h1;
      CHS_MODE_3W: oh = 4'h2;
      CHS_MODE_DUAL: oh = 4'h4;
      CHS_MODE_QUAD: oh = 4'h8;
      default: oh = 4'h0;
    endcase
    return oh;
  endfunction

  // Address held once per channel
  function automatic logic chs_is_chan_addr(input logic [4:0] addr);
    return (addr >= CHS_CHAN_ADDR_LO) && (addr <= CHS_PROF_ADDR_HI);
  endfunction

endpackage

// ===== include/chs_steer_if.sv
// Purpose: Carries a completed register write and the channel enables to the steering slice
// Assumes: One write at most per clock
// Notes: Steered strobes come back registered
`timescale 1ns/100ps
interface chs_steer_if
#(
  parameter int NUM_CHAN = 4,
  parameter int DATA_W = 32
);
  logic wr;
  logic [4:0] addr;
  logic [DATA_W-1:0] data;
  logic [NUM_CHAN-1:0] en;
  logic [NUM_CHAN-1:0] chan_wr;
  logic [4:0] chan_addr;
  logic [DATA_W-1:0] chan_data;

  modport src
  (
    output wr,
    output addr,
    output data,
    output en,
    input chan_wr,
    input chan_addr,
    input chan_data
  );

  modport snk
  (
    input wr,
    input addr,
    input data,
    input en,
    output chan_wr,
    output chan_addr,
    output chan_data
  );
endinterface

// ===== rtl/chs_steer.sv
// Purpose: Turns a shared channel or profile write into per-channel write strobes
// Assumes: Enables are current at the cycle the write is presented
// Notes: Strobes, address and data are registered
`timescale 1ns/100ps
module chs_steer
  import chs_pkg::*;
#(
  parameter int NUM_CHAN = 4,
  parameter int DATA_W = 32
)
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  chs_steer_if.snk sif
);

  // ==========================================================================
  // State
  logic [NUM_CHAN-1:0] chan_wr_d;
  logic [NUM_CHAN-1:0] chan_wr_q;
  logic [4:0] chan_addr_d;
  logic [4:0] chan_addr_q;
  logic [DATA_W-1:0] chan_data_d;
  logic [DATA_W-1:0] chan_data_q;
  logic hit;

  assign hit = sif.wr && chs_is_chan_addr(sif.addr);

  // ==========================================================================
  // Per-channel strobes
  genvar g;
  generate
    for (g = 0; g < NUM_CHAN; g++)
    begin : g_chan
      assign chan_wr_d[g] = hit && sif.en[g];
    end
  endgenerate

  always_comb
  begin
    chan_addr_d = chan_addr_q;
    chan_data_d = chan_data_q;
    if (hit)
    begin
      chan_addr_d = sif.addr;
      chan_data_d = sif.data;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      chan_wr_q <= '0;
      chan_addr_q <= '0;
      chan_data_q <= '0;
    end
    else
    begin
      chan_wr_q <= chan_wr_d;
      chan_addr_q <= chan_addr_d;
      chan_data_q <= chan_data_d;
    end
  end

  assign sif.chan_wr = chan_wr_q;
  assign sif.chan_addr = chan_addr_q;
  assign sif.chan_data = chan_data_q;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);

  a_steer_selected: assert property (
    hit |=> (chan_wr_q == $past(sif.en)) && (chan_addr_q == $past(sif.addr)))
  else $error("Channel strobes differ from enables");

  a_steer_other_addr: assert property (
    !hit |=> (chan_wr_q == '0))
  else $error("Channel strobe without channel write");

endmodule

// ===== tb/chs_host.sv
// Purpose: Host model that writes registers and frames serial transfers
// Assumes: One write a cycle, driven 1 ns after the rising edge
// Notes: Idle address and data are inverted on each stop, then held until the next put
`timescale 1ns/100ps
module chs_host
(
  input wire logic clock_i,
  output logic reg_wr_o,
  output logic [4:0] reg_addr_o,
  output logic [31:0] reg_wdata_o,
  output logic xfer_active_o
);
  initial
  begin
    reg_wr_o = 1'b0;
    reg_addr_o = 5'h00;
    reg_wdata_o = 32'h0;
    xfer_active_o = 1'b0;
  end

  // ====================
  // Access tasks
  task automatic put(input logic [4:0] a, input logic [31:0] d);
    reg_wr_o = 1'b1;
    reg_addr_o = a;
    reg_wdata_o = (a == 5'h00) ? (d & 32'hffff_fff7) : d;
    @(posedge clock_i);
    #1;
  endtask

  task automatic stop();
    reg_wr_o = 1'b0;
    reg_addr_o = ~reg_addr_o;
    reg_wdata_o = ~reg_wdata_o;
    @(posedge clock_i);
    #1;
  endtask

  task automatic xfer(input logic v);
    xfer_active_o = v;
  endtask
endmodule

// ===== tb/tb.sv
// Purpose: Self-checking bench for the channel select register
// Assumes: Host model drives all write and transfer inputs
// Notes: Expected values follow the register field layout
`timescale 1ns/100ps
module tb;
  import chs_pkg::*;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic reg_wr, xfer;
  logic [4:0] reg_addr, caddr;
  logic [31:0] reg_wdata, cdata;
  logic [7:0] chsel;
  logic [3:0] en, cwr;
  logic [1:0] mode;
  logic m2w, m3w, mdual, mquad, lsb;
  logic [2:0] prev = 3'h0;
  int n_errors = 0;
  int cmp_count = 0;

  always #4 clock_i = ~clock_i;

  chs_host host_u(.clock_i(clock_i), .reg_wr_o(reg_wr), .reg_addr_o(reg_addr),
    .reg_wdata_o(reg_wdata), .xfer_active_o(xfer));

  chs_top dut_u(.clock_i(clock_i), .rst_n_i(rst_n_i), .reg_wr_i(reg_wr),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .xfer_active_i(xfer),
    .channel_select_o(chsel), .chan_en_o(en), .chan_wr_o(cwr), .chan_addr_o(caddr),
    .chan_wdata_o(cdata), .serial_mode_o(mode), .mode_two_wire_o(m2w),
    .mode_three_wire_o(m3w), .mode_dual_o(mdual), .mode_quad_o(mquad),
    .lsb_first_o(lsb));

  // ====================
  // Compare and closing tasks
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_mode(input logic [1:0] m, input logic o);
    chk("serial_mode", {30'h0, m}, {30'h0, mode});
    chk("mode_onehot", 32'h1 << m, {28'h0, mquad, mdual, m3w, m2w});
    chk("lsb_first", {31'h0, o}, {31'h0, lsb});
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ====================
  // Tests
  initial
  begin
    repeat (6) @(posedge clock_i);
    #1;
    rst_n_i = 1'b1;
    chk("channel_select", 32'hf0, {24'h0, chsel});
    chk("chan_en", 32'hf, {28'h0, en});
    chk_mode(2'h0, 1'b0);
    $display("test reset done");
    host_u.put(CHS_SEL_ADDR, 32'h92);
    chk("channel_select", 32'h92, {24'h0, chsel});
    chk("chan_en", 32'h9, {28'h0, en});
    host_u.put(5'h04, 32'h1234_5678);
    chk("chan_wr", 32'h9, {28'h0, cwr});
    chk("chan_addr", 32'h4, {27'h0, caddr});
    chk("chan_wdata", 32'h1234_5678, cdata);
    host_u.put(CHS_SEL_ADDR, 32'h20);
    host_u.put(CHS_PROF_ADDR_HI, 32'hcafe_0001);
    chk("chan_wr", 32'h2, {28'h0, cwr});
    host_u.put(5'h01, 32'h0000_00ff);
    chk("chan_wr", 32'h0, {28'h0, cwr});
    host_u.put(5'h19, 32'h0000_0055);
    chk("chan_wr", 32'h0, {28'h0, cwr});
    host_u.stop();
    chk("channel_select", 32'h20, {24'h0, chsel});
    chk("chan_addr", 32'h18, {27'h0, caddr});
    chk("chan_wr", 32'h0, {28'h0, cwr});
    $display("test steer done");
    for (int i = 0; i < 8; i++)
    begin
      host_u.xfer(1'b1);
      host_u.put(CHS_SEL_ADDR, {24'h0, 4'hf, 1'b0, i[2:0]});
      host_u.stop();
      chk("channel_select", {24'h0, 4'hf, 1'b0, i[2:0]}, {24'h0, chsel});
      chk_mode(prev[2:1], prev[0]);
      host_u.xfer(1'b0);
      @(posedge clock_i);
      #1;
      chk_mode(i[2:1], i[0]);
      prev = i[2:0];
    end
    $display("test modes done");
    end_of_test();
  end

  initial
  begin
    #(2000 * 8);
    n_errors++;
    $display("watchdog expired");
    end_of_test();
  end
endmodule
